/* include/adc_port_regs.vh */
// Constants for the shared output pin block: register map, fields, timing.
// Assumes inclusion by bare name from design files.
`ifndef ADC_PORT_REGS_VH
`define ADC_PORT_REGS_VH
`define MODE_SERIAL 2'h3
`define OFS_CTRL 12'h000
`define OFS_RESULT 12'h004
`define OFS_STATUS 12'h008
`define CTRL_MODE_LSB 0
`define CTRL_START_BIT 4
`define STAT_BUSY_BIT 0
`define STAT_SYNC_ACT_BIT 1
`define STAT_SERIAL_DATA_IN_BIT 2
`define STAT_CFG_LSB 4
`define SCLK_HALF_NS 40
`define CLK_NS 10
`define SCLK_HALF_CYC (`SCLK_HALF_NS / `CLK_NS)
`define CONV_CYC 8'h40
`endif

/* logic/adc_output_port_pins.v */
// Shared data pins 7..9 of the converter output port and the serial read engine.
// Assumes a single AHB-Lite master on clk; pins and the external serial clock are
// asynchronous and pass two flip-flops before use.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_regs.vh"

module adc_output_port_pins #(
    parameter WIDTH = 18
) (
    input wire clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [WIDTH-1:0] conv_result,
    input wire clock_source_select,
    input wire ext_sclk,
    input wire chip_select_n,
    input wire parallel_bit_seven_in,
    input wire parallel_bit_eight_in,
    input wire parallel_bit_nine_in,
    output reg parallel_bit_seven_out,
    output reg parallel_bit_eight_out,
    output reg parallel_bit_nine_out,
    output reg parallel_bits_oe,
    output reg serial_clock_out,
    output reg serial_sync_out,
    output reg serial_data_out
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: first stage read only by second
reg [5:0] sync1_q;
reg [5:0] sync2_q;
always @(posedge clk) begin
    if (rst) begin
        // Chip select idles high: no false select right after reset
        sync1_q <= 6'h20;
        sync2_q <= 6'h20;
    end else begin
        sync1_q <= {chip_select_n, ext_sclk, clock_source_select,
                    parallel_bit_nine_in, parallel_bit_eight_in, parallel_bit_seven_in};
        sync2_q <= sync1_q;
    end
end
wire sync_polarity_select = sync2_q[0];
wire serial_clock_invert_select = sync2_q[1];
wire read_during_conversion_select = sync2_q[2];
wire serial_data_in = sync2_q[2];
wire slave_mode = sync2_q[3];
wire ext_clk_s = sync2_q[4];
wire cs_n_s = sync2_q[5];

////////////////////////////////////////////////////////////////////////////////
// AHB-Lite slave, zero wait states
reg [1:0] mode_q;
reg start_q;
reg wr_pend_q;
reg rd_pend_q;
reg [11:0] addr_q;
reg [31:0] rdata_q;
wire take = hsel && hready && htrans[1];
wire serial = (mode_q == `MODE_SERIAL);
reg busy_q;
reg [WIDTH-1:0] cur_q;
reg [WIDTH-1:0] prev_q;
reg sync_act_q;

assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = rdata_q;

always @(posedge clk) begin
    if (rst) begin
        mode_q <= 2'h0;
        start_q <= 1'b0;
        wr_pend_q <= 1'b0;
        rd_pend_q <= 1'b0;
        addr_q <= 12'h000;
        rdata_q <= 32'h00000000;
    end else begin
        start_q <= 1'b0;
        wr_pend_q <= take && hwrite;
        rd_pend_q <= take && !hwrite;
        if (take) addr_q <= haddr[11:0];
        if (wr_pend_q && addr_q == `OFS_CTRL) begin
            mode_q <= hwdata[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
            start_q <= hwdata[`CTRL_START_BIT];
        end
        if (take && !hwrite) begin
            case (haddr[11:0])
                `OFS_CTRL: rdata_q <= {30'h0, mode_q};
                `OFS_RESULT: rdata_q <= {{(32-WIDTH){1'b0}}, cur_q};
                `OFS_STATUS: rdata_q <= {26'h0, slave_mode, serial_clock_invert_select,
                                         1'b0, serial_data_in, sync_act_q, busy_q};
                default: rdata_q <= 32'h00000000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Parallel pins
always @(posedge clk) begin
    if (rst) begin
        parallel_bits_oe <= 1'b0;
        parallel_bit_seven_out <= 1'b0;
        parallel_bit_eight_out <= 1'b0;
        parallel_bit_nine_out <= 1'b0;
    end else begin
        parallel_bits_oe <= !serial;
        parallel_bit_seven_out <= serial ? 1'b0 : conv_result[7];
        parallel_bit_eight_out <= serial ? 1'b0 : conv_result[8];
        parallel_bit_nine_out <= serial ? 1'b0 : conv_result[9];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Conversion timing and serial engine
localparam S_IDLE = 2'h0;
localparam S_SHIFT = 2'h1;
localparam S_WAIT = 2'h2;
reg [1:0] state_q;
reg [7:0] conv_cnt_q;
reg [7:0] half_cnt_q;
reg [5:0] bit_cnt_q;
reg [WIDTH-1:0] shreg_q;
reg sclk_q;
reg ext_d_q;
reg rdc_q;
wire ext_fall = ext_d_q && !ext_clk_s;
// Full-width copies so that the counters take deliberate slices
wire [31:0] half_full = `SCLK_HALF_CYC;
wire [31:0] width_full = WIDTH;

always @(posedge clk) begin
    if (rst) begin
        busy_q <= 1'b0;
        conv_cnt_q <= 8'h00;
        cur_q <= {WIDTH{1'b0}};
        prev_q <= {WIDTH{1'b0}};
    end else if (start_q && !busy_q) begin
        busy_q <= 1'b1;
        conv_cnt_q <= `CONV_CYC;
        prev_q <= cur_q;
    end else if (busy_q) begin
        conv_cnt_q <= conv_cnt_q - 8'h01;
        if (conv_cnt_q == 8'h01) begin
            busy_q <= 1'b0;
            cur_q <= conv_result;
        end
    end
end

always @(posedge clk) begin
    if (rst) begin
        state_q <= S_IDLE;
        half_cnt_q <= 8'h00;
        bit_cnt_q <= 6'h00;
        shreg_q <= {WIDTH{1'b0}};
        sclk_q <= 1'b0;
        sync_act_q <= 1'b0;
        ext_d_q <= 1'b0;
        rdc_q <= 1'b0;
    end else begin
        ext_d_q <= ext_clk_s;
        case (state_q)
            S_IDLE: begin
                sclk_q <= 1'b0;
                if (serial && !slave_mode && start_q && !busy_q) begin
                    rdc_q <= read_during_conversion_select;
                    if (read_during_conversion_select) begin
                        shreg_q <= cur_q;
                        bit_cnt_q <= width_full[5:0];
                        half_cnt_q <= half_full[7:0];
                        sync_act_q <= 1'b1;
                        state_q <= S_SHIFT;
                    end else begin
                        state_q <= S_WAIT;
                    end
                end else if (serial && slave_mode && !cs_n_s) begin
                    shreg_q <= cur_q;
                    bit_cnt_q <= width_full[5:0];
                    state_q <= S_SHIFT;
                end
            end
            S_WAIT: begin
                if (!busy_q && !start_q) begin
                    shreg_q <= cur_q;
                    bit_cnt_q <= width_full[5:0];
                    half_cnt_q <= {half_full[6:0], 1'b0}; // Twice the conversion-time half period; later halves reload at half of it
                    sync_act_q <= 1'b1;
                    state_q <= S_SHIFT;
                end
            end
            S_SHIFT: begin
                if (slave_mode) begin
                    if (cs_n_s) begin
                        state_q <= S_IDLE;
                    end else if (ext_fall) begin
                        shreg_q <= {shreg_q[WIDTH-2:0], serial_data_in};
                        if (bit_cnt_q != 6'h00) bit_cnt_q <= bit_cnt_q - 6'h01;
                    end
                end else if (half_cnt_q > 8'h01) begin
                    half_cnt_q <= half_cnt_q - 8'h01;
                end else begin
                    half_cnt_q <= rdc_q ? half_full[7:0] : half_full[8:1];
                    sclk_q <= !sclk_q;
                    if (sclk_q) begin
                        shreg_q <= {shreg_q[WIDTH-2:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q - 6'h01;
                        if (bit_cnt_q == 6'h01) begin
                            sync_act_q <= 1'b0;
                            state_q <= S_IDLE;
                        end
                    end
                end
            end
            default: state_q <= S_IDLE;
        endcase
    end
end

always @(posedge clk) begin
    if (rst) begin
        serial_clock_out <= 1'b0;
        serial_sync_out <= 1'b0;
        serial_data_out <= 1'b0;
    end else begin
        serial_clock_out <= serial && (sclk_q ^ serial_clock_invert_select);
        serial_sync_out <= serial && (sync_act_q ^ sync_polarity_select);
        serial_data_out <= serial && shreg_q[WIDTH-1];
    end
end

endmodule // adc_output_port_pins
`default_nettype wire

/* verif/adc_pins_properties.sv */
// Checker for the shared pin block, bound to the design module.
// Assumes clk with rst synchronous active high.
`timescale 1ns/1ps
`default_nettype none
module adc_pins_properties #(parameter WIDTH = 18) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] conv_result,
    input wire hreadyout,
    input wire hresp,
    input wire parallel_bit_seven_out,
    input wire parallel_bit_eight_out,
    input wire parallel_bit_nine_out,
    input wire parallel_bits_oe,
    input wire serial_clock_out,
    input wire serial_sync_out,
    input wire serial_data_out
);
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
a_bit_seven_follow: assert property (parallel_bits_oe |->
    parallel_bit_seven_out == $past(conv_result[7])) else $error("bit seven wrong");
a_bit_eight_follow: assert property (parallel_bits_oe |->
    parallel_bit_eight_out == $past(conv_result[8])) else $error("bit eight wrong");
a_bit_nine_follow: assert property (parallel_bits_oe |->
    parallel_bit_nine_out == $past(conv_result[9])) else $error("bit nine wrong");
a_pins_released: assert property (!parallel_bits_oe |-> !parallel_bit_seven_out &&
    !parallel_bit_eight_out && !parallel_bit_nine_out) else $error("pin driven");
a_no_serial_clock: assert property (parallel_bits_oe |-> !serial_clock_out)
    else $error("clock outside serial");
a_no_sync_data: assert property (parallel_bits_oe |-> !serial_sync_out &&
    !serial_data_out) else $error("sync or data outside serial");
a_reset_clears: assert property ($fell(rst) |-> !parallel_bits_oe && !serial_data_out)
    else $error("outputs after reset");
a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer");
cover property ($rose(parallel_bits_oe));
cover property ($rose(serial_clock_out));
cover property ($rose(serial_data_out));
endmodule // adc_pins_properties
bind adc_output_port_pins adc_pins_properties #(.WIDTH(WIDTH)) i_props (.clk, .rst,
    .conv_result, .hreadyout, .hresp, .parallel_bit_seven_out, .parallel_bit_eight_out,
    .parallel_bit_nine_out, .parallel_bits_oe, .serial_clock_out, .serial_sync_out,
    .serial_data_out);
`default_nettype wire

/* verif/slave_reader.sv */
// Far-side reader for slave mode: gated link clock, collects the output line.
// Assumes go rises once; the clock stands still low outside the frame.
`timescale 1ns/1ps
`default_nettype none
module slave_reader (
    input wire logic go,
    input wire logic serial_data_out,
    output logic ext_sclk,
    output logic chip_select_n,
    output logic [19:0] word,
    output logic done
);
initial begin
    {ext_sclk, chip_select_n, word, done} = {1'b0, 1'b1, 20'h0, 1'b0};
    @(posedge go);
    #13 chip_select_n = 0; // Odd offset keeps it unrelated to clk
    repeat (20) begin
        #80 ext_sclk = 1;
        word = {word[18:0], serial_data_out}; // Own bits, then chained input
        #80 ext_sclk = 0;
    end
    #80 chip_select_n = 1;
    done = 1;
end
endmodule // slave_reader
`default_nettype wire

/* verif/adc_output_port_pin_config_bench.sv */
// Bench: bus tasks, expected-result queue, slave reader on the far side.
// Assumes the design header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_regs.vh"
module adc_output_port_pin_config_bench;
logic clk, rst, hsel, hwrite, p7, p8, p9, ccs, go;
logic [1:0] htrans;
logic [31:0] haddr, hwdata, r, v;
logic [17:0] res;
logic ps;
logic [17:0] got, last;
wire [31:0] hrdata;
wire hready, hresp, o7, o8, o9, oe, sclk, sync, sdo, esclk, csn, done;
wire [19:0] word;
int n_mismatch, comparisons, cyc, k, n;
logic [17:0] exp_q[$];
adc_output_port_pins i_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .conv_result(res),
    .clock_source_select(ccs), .ext_sclk(esclk), .chip_select_n(csn),
    .parallel_bit_seven_in(p7), .parallel_bit_eight_in(p8), .parallel_bit_nine_in(p9),
    .parallel_bit_seven_out(o7), .parallel_bit_eight_out(o8), .parallel_bit_nine_out(o9),
    .parallel_bits_oe(oe), .serial_clock_out(sclk), .serial_sync_out(sync),
    .serial_data_out(sdo));
slave_reader i_reader (.go, .serial_data_out(sdo), .ext_sclk(esclk), .chip_select_n(csn),
    .word, .done);
////////////////////////////////////////////////////////////////////////////////
task report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
        n_mismatch++;
        $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
endtask
task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, w};
    do @(posedge clk); while (hready !== 1'b1);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    clk = 0;
    forever #5 clk = ~clk;
end
always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
        n_mismatch++;
        report_and_stop();
    end
end
initial begin
    {rst, hsel, haddr, htrans, hwrite, hwdata, res} = {1'b1, 86'h0};
    {p7, p8, p9, ccs, go} = 5'h0;
    last = 18'h0;
    v = $urandom(32'h26ffae6e);
    repeat (2) @(posedge clk);
    rst <= 0;
    for (k = 0; k < 3; k++) begin
        res <= $urandom;
        bus(`OFS_CTRL, 1, k);
        repeat (3) @(posedge clk);
        chk("parallel", {1'b1, res[9:7]}, {oe, o9, o8, o7});
    end
    // Plain, both inverted, then read during conversion; host sets the pins
    for (k = 0; k < 3; k++) begin
        {p7, p8, p9} <= {k[0], k[0], k == 2};
        bus(`OFS_CTRL, 1, 32'h3);
        repeat (6) @(posedge clk);
        chk("oe", 0, oe);
        v = $urandom;
        res <= v[17:0];
        exp_q.push_back(v[17:0]);
        bus(`OFS_CTRL, 1, 32'h13);
        n = 0;
        ps = sclk;
        got = 18'h0;
        // Data taken on each uninverted rising edge of the serial clock
        repeat (400) begin
            @(posedge clk);
            if (sclk !== ps) begin
                n++;
                if (sclk !== p8) got = {got[16:0], sdo};
            end
            ps = sclk;
        end
        chk("edges", 36, n);
        chk("serial", (k == 2) ? last : v[17:0], got);
        last = v[17:0];
        chk("idle", {p8, p7}, {sclk, sync});
        bus(`OFS_RESULT, 0, 0);
        chk("result", exp_q.pop_front(), r);
        bus(`OFS_STATUS, 0, 0);
        chk("status", {ccs, p8, p9}, {r[5:4], r[2]});
    end
    bus(32'h0c, 0, 0);
    chk("unmapped", 0, r);
    {ccs, p8, p9} <= 3'h5;
    bus(`OFS_CTRL, 1, 32'h3);
    repeat (6) @(posedge clk);
    v = $urandom;
    res <= v[17:0];
    bus(`OFS_CTRL, 1, 32'h13);
    repeat (`CONV_CYC + 8) @(posedge clk);
    go <= 1;
    wait (done === 1'b1);
    chk("slave", {v[17:0], 2'h3}, word);
    report_and_stop();
end
endmodule // adc_output_port_pin_config_bench
`default_nettype wire
